// ==== access_check.v ====
// segment limit, overrun and alignment checks on a memory operand
`timescale 1ns/10ps
`default_nettype none
`include "fp_exc_consts.vh"

module access_check (
    // access description
    input  wire        access_i,
    input  wire [31:0] addr_i,
    input  wire [4:0]  size_i,
    input  wire [31:0] limit_i,
    input  wire        ac_en_i,
    input  wire [1:0]  cpl_i,
    input  wire        stack_part_i,
    // verdicts
    output wire        gp_o,
    output wire        abort_o,
    output wire        ac_o
);

    wire [32:0] last_byte;
    wire [31:0] size_mask;

    assign last_byte = {1'b0, addr_i} + {28'h0, size_i} - 33'h1;
    assign size_mask = {27'h0, size_i} - 32'h1;

    // start beyond the segment is a protection fault
    assign gp_o    = access_i && (addr_i > limit_i);
    // tail beyond the segment aborts instead of the old overrun trap
    assign abort_o = access_i && !gp_o && (last_byte > {1'b0, limit_i});
    // user-level misalignment, stack part of save/restore exempt
    assign ac_o    = access_i && ac_en_i && (cpl_i == 2'h3) && !stack_part_i
                     && ((addr_i & size_mask) != 32'h0);

endmodule // access_check
`default_nettype wire

// ==== fp_exc_consts.vh ====
// constants for the floating-point exception and operand-check block
`ifndef FP_EXC_CONSTS_VH
`define FP_EXC_CONSTS_VH

// exception vectors; all but the overrun vector are delivered to the processor
`define VEC_GP            8'h0d
`define VEC_FLOAT_ERR     8'h10
`define VEC_AC_DEFAULT    8'h11
`define VEC_OVERRUN       8'h09

// operation codes on op_code_i
`define OP_NONE           5'h00
`define OP_SQRT           5'h01
`define OP_DIV            5'h02
`define OP_REM_LEGACY     5'h03
`define OP_REM_IEEE       5'h04
`define OP_TO_BCD         5'h05
`define OP_TO_INT         5'h06
`define OP_ENV_LOAD       5'h07
`define OP_SCALE          5'h08
`define OP_UCOM           5'h09
`define OP_UCOM_POP       5'h0a
`define OP_UCOM_POP2      5'h0b
`define OP_TAN            5'h0c
`define OP_SIN            5'h0d
`define OP_COS            5'h0e
`define OP_SINCOS         5'h0f
`define OP_ATAN           5'h10
`define OP_EXP2M1         5'h11
`define OP_LOAD           5'h12

// memory operand formats on mem_fmt_i
`define FMT_EXT           2'h0
`define FMT_SINGLE        2'h1
`define FMT_DOUBLE        2'h2

// destination kinds for the indefinite value
`define KIND_REAL         2'h0
`define KIND_INT          2'h1
`define KIND_BCD          2'h2

// extended-real field layout and exponent figures
`define EXP_BIAS          15'h3fff
`define EXP_MAX           15'h7fff
`define EXP_TAN_LIMIT     15'h403e
`define EXP_SGL_BIAS      15'h007f
`define EXP_DBL_BIAS      15'h03ff
`define EXP_SGL_DEN       15'h3f81
`define EXP_DBL_DEN       15'h3c01

// indefinite encodings and the reduction constant
`define IND_REAL          80'hffffc000000000000000
`define IND_INT           80'h00008000000000000000
`define IND_BCD           80'hffffc000000000000000
`define PI_OVER_4         80'h3ffec90fdaa22168c235

`endif

// ==== fp_exception_and_op_rules.v ====
// top of the floating-point exception and operand-check block
`timescale 1ns/10ps
`default_nettype none
`include "fp_exc_consts.vh"

module fp_exception_and_op_rules #(
    parameter [7:0] AC_VECTOR = `VEC_AC_DEFAULT
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        resetn_i,
    // operation request
    input  wire        op_valid_i,
    output wire        op_ready_o,
    input  wire [4:0]  op_code_i,
    input  wire [79:0] top_i,
    input  wire [79:0] next_i,
    input  wire [79:0] mem_data_i,
    input  wire [1:0]  mem_fmt_i,
    // status from the arithmetic datapath
    input  wire        inv_mask_i,
    input  wire        und_mask_i,
    input  wire        inexact_i,
    input  wire        tiny_i,
    input  wire        loss_i,
    input  wire [2:0]  quot_i,
    input  wire        rem_partial_i,
    input  wire        stack_ovf_i,
    input  wire [1:0]  dest_kind_i,
    // memory access description
    input  wire        mem_access_i,
    input  wire [31:0] addr_i,
    input  wire [4:0]  size_i,
    input  wire [31:0] limit_i,
    input  wire        ac_en_i,
    input  wire [1:0]  cpl_i,
    input  wire        stack_part_i,
    // environment probe port
    output reg         probe_req_o,
    output reg  [31:0] probe_addr_o,
    input  wire        probe_ack_i,
    input  wire        probe_fault_i,
    input  wire [7:0]  probe_vec_i,
    // results
    output reg         done_o,
    output reg         exc_valid_o,
    output reg  [7:0]  exc_vector_o,
    output reg         abort_o,
    output reg         env_commit_o,
    output reg         invalid_o,
    output reg         denorm_o,
    output reg         underflow_o,
    output reg         precision_o,
    output reg         normalize_o,
    output reg  [3:0]  cond_o,
    output reg  [1:0]  pop_o,
    output reg         result_wr_o,
    output reg  [79:0] result_o
);

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_FIRST = 3'b010;
    localparam [2:0] ST_LAST  = 3'b100;

    reg  [2:0]  state_r;
    reg  [31:0] last_addr_r;
    wire        take;
    wire        gp;
    wire        ovr_abort;
    wire        ac;
    wire [79:0] wide;
    wire        wide_snan;
    wire        wide_den;

    // operand classes of the two stack registers
    wire        top_zero  = (top_i[78:64] == 15'h0) && (top_i[63:0] == 64'h0);
    wire        next_zero = (next_i[78:64] == 15'h0) && (next_i[63:0] == 64'h0);
    wire        top_den   = (top_i[78:64] == 15'h0) && !top_zero;
    wire        next_den  = (next_i[78:64] == 15'h0) && !next_zero;
    wire        top_nan   = (top_i[78:64] == `EXP_MAX) && (top_i[62:0] != 63'h0);
    wire        next_nan  = (next_i[78:64] == `EXP_MAX) && (next_i[62:0] != 63'h0);
    wire        top_snan  = top_nan && !top_i[62];
    wire        next_snan = next_nan && !next_i[62];
    wire        top_lt1   = top_i[78:64] < `EXP_BIAS;
    wire        next_lt1  = next_i[78:64] < `EXP_BIAS;
    wire        top_lt63  = top_i[78:64] < `EXP_TAN_LIMIT;
    wire        top_gt_nx = (top_i[79] != next_i[79]) ? next_i[79]
                            : ((top_i[78:0] > next_i[78:0]) ^ top_i[79]);
    // compare variant index; only the low two bits are a pop count
    wire [4:0]  ucom_idx  = op_code_i - `OP_UCOM;

    assign op_ready_o = state_r[0];
    assign take       = op_valid_i && op_ready_o;

    operand_widen u_widen (
        .raw_i    (mem_data_i),
        .fmt_i    (mem_fmt_i),
        .ext_o    (wide),
        .snan_o   (wide_snan),
        .denorm_o (wide_den)
    );

    access_check u_access (
        .access_i     (mem_access_i),
        .addr_i       (addr_i),
        .size_i       (size_i),
        .limit_i      (limit_i),
        .ac_en_i      (ac_en_i),
        .cpl_i        (cpl_i),
        .stack_part_i (stack_part_i),
        .gp_o         (gp),
        .abort_o      (ovr_abort),
        .ac_o         (ac)
    );

    // per-operation decision, all outputs registered
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r      <= ST_IDLE;
            last_addr_r  <= 32'h0;
            probe_req_o  <= 1'b0;
            probe_addr_o <= 32'h0;
            done_o       <= 1'b0;
            exc_valid_o  <= 1'b0;
            exc_vector_o <= 8'h0;
            abort_o      <= 1'b0;
            env_commit_o <= 1'b0;
            invalid_o    <= 1'b0;
            denorm_o     <= 1'b0;
            underflow_o  <= 1'b0;
            precision_o  <= 1'b0;
            normalize_o  <= 1'b0;
            cond_o       <= 4'h0;
            pop_o        <= 2'h0;
            result_wr_o  <= 1'b0;
            result_o     <= 80'h0;
        end else begin
            // pulses default low each cycle
            done_o       <= 1'b0;
            exc_valid_o  <= 1'b0;
            abort_o      <= 1'b0;
            env_commit_o <= 1'b0;
            result_wr_o  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        invalid_o   <= 1'b0;
                        denorm_o    <= 1'b0;
                        underflow_o <= 1'b0;
                        precision_o <= 1'b0;
                        normalize_o <= 1'b0;
                        pop_o       <= 2'h0;
                        cond_o      <= 4'h0;
                        // access faults win; overrun never reaches vector 9
                        if (gp) begin
                            done_o       <= 1'b1;
                            exc_valid_o  <= 1'b1;
                            exc_vector_o <= `VEC_GP;
                        end else if (ovr_abort) begin
                            done_o  <= 1'b1;
                            abort_o <= 1'b1;
                        end else if (ac) begin
                            done_o       <= 1'b1;
                            exc_valid_o  <= 1'b1;
                            exc_vector_o <= AC_VECTOR;
                        end else if (stack_ovf_i) begin
                            // overflow: indefinite when masked, error trap otherwise
                            done_o      <= 1'b1;
                            invalid_o   <= 1'b1;
                            cond_o      <= 4'b0010;
                            result_wr_o <= inv_mask_i;
                            result_o    <= (dest_kind_i == `KIND_INT) ? `IND_INT
                                           : (dest_kind_i == `KIND_BCD) ? `IND_BCD
                                           : `IND_REAL;
                            exc_valid_o  <= !inv_mask_i;
                            exc_vector_o <= `VEC_FLOAT_ERR;
                        end else if (op_code_i == `OP_ENV_LOAD) begin
                            // probe both ends before touching any state
                            state_r      <= ST_FIRST;
                            probe_req_o  <= 1'b1;
                            probe_addr_o <= addr_i;
                            last_addr_r  <= addr_i + {27'h0, size_i} - 32'h1;
                        end else begin
                            done_o <= 1'b1;
                            case (op_code_i)
                                `OP_SQRT, `OP_DIV, `OP_REM_LEGACY, `OP_REM_IEEE: begin
                                    // denormals are normalised, never invalid
                                    denorm_o    <= top_den || next_den;
                                    normalize_o <= top_den || next_den;
                                    underflow_o <= tiny_i && (!und_mask_i || loss_i);
                                    precision_o <= inexact_i;
                                    invalid_o   <= top_snan || next_snan;
                                    exc_valid_o <= (top_snan || next_snan) && !inv_mask_i
                                                   || tiny_i && !und_mask_i;
                                    exc_vector_o <= `VEC_FLOAT_ERR;
                                    if (op_code_i == `OP_REM_LEGACY ||
                                        op_code_i == `OP_REM_IEEE) begin
                                        // quotient bits: q1 to flag 3, q0 to 1, q2 to 0
                                        cond_o <= {quot_i[1], rem_partial_i,
                                                   quot_i[0], quot_i[2]};
                                    end
                                end
                                `OP_TO_BCD, `OP_TO_INT: begin
                                    denorm_o    <= top_den;
                                    normalize_o <= top_den;
                                    precision_o <= inexact_i;
                                end
                                `OP_SCALE: begin
                                    // fractional scaler: factor zero, top kept
                                    if (!next_zero && next_lt1 && !next_nan) begin
                                        result_wr_o <= 1'b1;
                                        result_o    <= top_i;
                                    end
                                    precision_o <= inexact_i || (und_mask_i && loss_i);
                                    underflow_o <= tiny_i && (!und_mask_i || loss_i);
                                end
                                `OP_UCOM, `OP_UCOM_POP, `OP_UCOM_POP2: begin
                                    // quiet nan gives unordered without invalid
                                    pop_o <= ucom_idx[1:0];
                                    if (top_nan || next_nan) begin
                                        cond_o <= 4'b1101;
                                    end else if (top_zero && next_zero ||
                                                 top_i == next_i) begin
                                        cond_o <= 4'b1000;
                                    end else begin
                                        cond_o <= {3'b000, !top_gt_nx};
                                    end
                                    invalid_o    <= top_snan || next_snan;
                                    exc_valid_o  <= (top_snan || next_snan) && !inv_mask_i;
                                    exc_vector_o <= `VEC_FLOAT_ERR;
                                end
                                `OP_TAN, `OP_SIN, `OP_COS, `OP_SINCOS: begin
                                    // out of range: flag 2 set, top untouched
                                    cond_o   <= {1'b0, !top_lt63, 2'b00};
                                    denorm_o <= top_den;
                                    if (top_lt63) begin
                                        result_wr_o <= 1'b1;
                                        result_o    <= `PI_OVER_4;
                                    end
                                end
                                `OP_ATAN: begin
                                    // no magnitude ordering demanded
                                    denorm_o <= top_den || next_den;
                                end
                                `OP_EXP2M1: begin
                                    cond_o   <= {1'b0, !top_lt1 && !top_nan, 2'b00};
                                    denorm_o <= top_den;
                                end
                                `OP_LOAD: begin
                                    // extended denormal is no arithmetic event
                                    denorm_o     <= wide_den;
                                    invalid_o    <= wide_snan;
                                    exc_valid_o  <= wide_snan && !inv_mask_i;
                                    exc_vector_o <= `VEC_FLOAT_ERR;
                                    result_wr_o  <= !wide_snan || inv_mask_i;
                                    result_o     <= wide;
                                end
                                default: begin
                                    cond_o <= 4'h0;
                                end
                            endcase
                        end
                    end
                end
                ST_FIRST: begin
                    if (probe_ack_i) begin
                        if (probe_fault_i) begin
                            // nothing loaded yet, state stays consistent
                            state_r      <= ST_IDLE;
                            probe_req_o  <= 1'b0;
                            done_o       <= 1'b1;
                            exc_valid_o  <= 1'b1;
                            exc_vector_o <= probe_vec_i;
                        end else begin
                            state_r      <= ST_LAST;
                            probe_addr_o <= last_addr_r;
                        end
                    end
                end
                ST_LAST: begin
                    if (probe_ack_i) begin
                        state_r      <= ST_IDLE;
                        probe_req_o  <= 1'b0;
                        done_o       <= 1'b1;
                        exc_valid_o  <= probe_fault_i;
                        exc_vector_o <= probe_vec_i;
                        env_commit_o <= !probe_fault_i;
                    end
                end
                default: begin
                    state_r     <= ST_IDLE;
                    probe_req_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // fp_exception_and_op_rules
`default_nettype wire

// ==== fp_exception_and_op_rules_sva.sv ====
// port assertions for the floating-point exception block
`timescale 1ns/10ps
`default_nettype none
`include "fp_exc_consts.vh"
module fp_exception_and_op_rules_sva #(parameter [7:0] AC_VECTOR = `VEC_AC_DEFAULT) (
    // clock, reset and request
    input wire logic        mclk_i, resetn_i, op_valid_i, op_ready_o,
    input wire logic [4:0]  op_code_i, size_i,
    input wire logic [79:0] top_i, next_i, result_o,
    // status and access
    input wire logic        inv_mask_i, und_mask_i, inexact_i, loss_i, stack_ovf_i,
    input wire logic        mem_access_i, ac_en_i, stack_part_i, probe_ack_i, probe_fault_i,
    input wire logic [1:0]  dest_kind_i, cpl_i,
    input wire logic [31:0] addr_i, limit_i, probe_addr_o,
    // results
    input wire logic        probe_req_o, done_o, exc_valid_o, abort_o, env_commit_o,
    input wire logic        precision_o, result_wr_o,
    input wire logic [7:0]  exc_vector_o
);
    // access verdicts; 33 bits so an end past 4 GB cannot wrap
    wire        take = op_valid_i && op_ready_o;
    wire [32:0] last = {1'b0, addr_i} + {28'h0, size_i} - 33'h1;
    wire        gp   = mem_access_i && addr_i > limit_i;
    wire        ovr  = mem_access_i && !gp && last > {1'b0, limit_i};
    wire        mis  = mem_access_i && ac_en_i && cpl_i == 2'h3 && !stack_part_i
                       && (addr_i & ({27'h0, size_i} - 32'h1)) != 32'h0;
    wire        base = take && !gp && !ovr && !mis && !stack_ovf_i;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    a_no_overrun_vec: assert property (exc_valid_o |-> exc_vector_o != `VEC_OVERRUN)
        else $error("overrun vector raised");
    a_overrun_abort: assert property (take && ovr |=> done_o && abort_o && !exc_valid_o)
        else $error("overrun did not abort");
    a_gp_vector: assert property (take && gp |=> exc_valid_o && exc_vector_o == `VEC_GP)
        else $error("limit fault missing");
    a_align_fault: assert property (take && !gp && !ovr && mis |=>
        exc_valid_o && exc_vector_o == AC_VECTOR) else $error("alignment fault missing");
    a_env_first_byte: assert property (base && op_code_i == `OP_ENV_LOAD |=>
        probe_req_o && probe_addr_o == $past(addr_i)) else $error("first probe wrong");
    a_commit_after_ack: assert property (env_commit_o |->
        $past(probe_ack_i) && !$past(probe_fault_i)) else $error("commit without probe");
    a_scale_keep: assert property (base && op_code_i == `OP_SCALE && next_i[78:0] != 79'h0
        && next_i[78:64] < `EXP_BIAS |=> result_wr_o && result_o == $past(top_i))
        else $error("scale changed top");
    a_scale_prec: assert property (base && op_code_i == `OP_SCALE |=>
        precision_o == ($past(inexact_i) || $past(und_mask_i) && $past(loss_i)))
        else $error("scale precision");
    a_ovf_indef: assert property (take && !gp && !ovr && !mis && stack_ovf_i && inv_mask_i
        |=> result_wr_o && result_o == ($past(dest_kind_i) == `KIND_INT ? `IND_INT
        : $past(dest_kind_i) == `KIND_BCD ? `IND_BCD : `IND_REAL)) else $error("indefinite");
endmodule // fp_exception_and_op_rules_sva
bind fp_exception_and_op_rules fp_exception_and_op_rules_sva #(.AC_VECTOR(AC_VECTOR)) u_sva (.*);
`default_nettype wire

// ==== fp_exception_and_op_rules_test.sv ====
// self-checking bench for the floating-point exception block
`timescale 1ns/10ps
`default_nettype none
`include "fp_exc_consts.vh"
`define CHK(a,b) begin n_compared++; if ((a)!==(b)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module fp_exception_and_op_rules_test;
    logic        mclk_i, resetn_i = 0, op_valid_i = 0, inv_mask_i, und_mask_i, inexact_i, tiny_i;
    logic        loss_i, rem_partial_i, stack_ovf_i, mem_access_i, ac_en_i, stack_part_i;
    logic        probe_ack_i, probe_fault_i, op_ready_o, probe_req_o, done_o, exc_valid_o;
    logic        abort_o, env_commit_o, invalid_o, denorm_o, underflow_o, precision_o;
    logic        normalize_o, result_wr_o;
    logic [4:0]  op_code_i, size_i;
    logic [79:0] top_i, next_i, mem_data_i, result_o;
    logic [1:0]  mem_fmt_i, dest_kind_i, cpl_i, pop_o;
    logic [2:0]  quot_i;
    logic [3:0]  cond_o;
    logic [31:0] addr_i, limit_i, probe_addr_o;
    logic [7:0]  probe_vec_i, exc_vector_o;
    int          n_errors = 0, n_compared = 0;

    fp_exception_and_op_rules dut (.*);

    // 200 MHz clock
    initial begin
        mclk_i = 0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // every input but the clock, resetn_i and op_valid_i back to a quiet value
    task clr;
        {inv_mask_i, und_mask_i, inexact_i, tiny_i, loss_i, rem_partial_i} = '0;
        {stack_ovf_i, mem_access_i, ac_en_i, stack_part_i, probe_ack_i, probe_fault_i} = '0;
        {op_code_i, size_i, top_i, next_i, mem_data_i, mem_fmt_i, dest_kind_i} = '0;
        {cpl_i, quot_i, addr_i, limit_i, probe_vec_i} = '0;
    endtask

    task go(input logic [4:0] c);
        @(posedge mclk_i) #1;
        op_code_i = c;
        op_valid_i = 1;
        @(posedge mclk_i);
        #1 op_valid_i = 0;
    endtask

    // bounded wait; a hang ends the run as a failure
    task wait_done;
        for (int i = 0; i < 20 && done_o !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        if (done_o !== 1'b1) begin
            n_errors++;
            test_done;
        end
    endtask

    task run(input logic [4:0] c);
        go(c);
        wait_done;
    endtask

    task ack(input logic [31:0] a, input logic f);
        for (int i = 0; i < 10 && probe_req_o !== 1'b1; i++) @(posedge mclk_i) #1;
        if (probe_req_o !== 1'b1) begin
            n_errors++;
            test_done;
        end
        `CHK({probe_req_o, op_ready_o, probe_addr_o}, {2'b10, a})
        probe_ack_i = 1;
        probe_fault_i = f;
        @(posedge mclk_i);
        #1 {probe_ack_i, probe_fault_i} = 2'b00;
    endtask

    task t_access;
        clr; mem_access_i = 1; limit_i = 32'hff; size_i = 5'h4; addr_i = 32'h100;
        run(`OP_DIV); `CHK({exc_valid_o, exc_vector_o}, {1'b1, `VEC_GP})
        addr_i = 32'hfe; run(`OP_DIV); `CHK({abort_o, exc_valid_o}, 2'b10)
        addr_i = 32'h2; ac_en_i = 1; cpl_i = 2'h3;
        run(`OP_DIV); `CHK(exc_vector_o, `VEC_AC_DEFAULT)
        stack_part_i = 1; run(`OP_DIV); `CHK(exc_valid_o, 1'b0)
        $display("access test done");
    endtask

    task t_env;
        clr; mem_access_i = 1; limit_i = 32'hfff; addr_i = 32'h100; size_i = 5'h1c;
        probe_vec_i = 8'h0b; go(`OP_ENV_LOAD); ack(32'h100, 0); @(posedge mclk_i) #1;
        ack(32'h11b, 0); wait_done; `CHK({env_commit_o, exc_valid_o}, 2'b10)
        go(`OP_ENV_LOAD); ack(32'h100, 1); wait_done; // fault on the first probe
        `CHK({env_commit_o, exc_valid_o, exc_vector_o}, {2'b01, 8'h0b})
        $display("environment test done");
    endtask

    task t_arith;
        logic [4:0] ops [5];
        ops = '{`OP_SQRT, `OP_DIV, `OP_REM_LEGACY, `OP_TO_BCD, `OP_TO_INT};
        clr; top_i = 80'h00004000000000000000; next_i = 80'h3fff8000000000000000; tiny_i = 1;
        for (int i = 0; i < 5; i++) begin
            run(ops[i]);
            `CHK({invalid_o, normalize_o, underflow_o}, {2'b01, 1'(i < 3)})
        end
        quot_i = 3'b110; rem_partial_i = 1; run(`OP_REM_LEGACY); `CHK(cond_o, 4'b1101)
        run(`OP_REM_IEEE); `CHK({done_o, invalid_o}, 2'b10)
        top_i = next_i;
        for (int i = 0; i < 3; i++) begin
            run(`OP_UCOM + 5'(i)); `CHK({cond_o, pop_o}, {4'b1000, 2'(i)})
        end
        next_i = 80'h7fffc000000000000000; run(`OP_UCOM); `CHK({cond_o, invalid_o}, 5'b11010)
        clr; top_i = 80'h4000c000000000000000; next_i = 80'h3ffe8000000000000000;
        und_mask_i = 1; loss_i = 1; run(`OP_SCALE);
        `CHK({result_wr_o, result_o, precision_o}, {1'b1, top_i, 1'b1})
        loss_i = 0; run(`OP_SCALE); `CHK(precision_o, 1'b0)
        $display("arithmetic test done");
    endtask

    task t_range;
        clr; top_i = 80'h403d8000000000000000;
        for (int i = 0; i < 4; i++) begin
            run(`OP_TAN + 5'(i)); `CHK({cond_o[2], result_o}, {1'b0, `PI_OVER_4})
        end
        top_i = 80'h403e8000000000000000; run(`OP_TAN); `CHK(cond_o[2], 1'b1)
        top_i = 80'hbffe8000000000000000; run(`OP_EXP2M1); `CHK(cond_o[2], 1'b0)
        top_i = 80'h3fff8000000000000000; run(`OP_EXP2M1); `CHK(cond_o[2], 1'b1)
        stack_ovf_i = 1; inv_mask_i = 1; dest_kind_i = `KIND_INT;
        run(`OP_LOAD); `CHK({result_wr_o, result_o}, {1'b1, `IND_INT})
        dest_kind_i = `KIND_BCD; run(`OP_LOAD); `CHK(result_o, `IND_BCD)
        clr; mem_data_i = 80'h1; run(`OP_LOAD); `CHK(denorm_o, 1'b0)
        mem_fmt_i = `FMT_SINGLE; run(`OP_LOAD);
        `CHK({denorm_o, result_o}, {1'b1, 80'h3f6a8000000000000000})
        mem_fmt_i = `FMT_DOUBLE; run(`OP_LOAD);
        `CHK(result_o, 80'h3bcd8000000000000000)
        mem_fmt_i = `FMT_SINGLE; mem_data_i = 80'h7fa00000; run(`OP_LOAD);
        `CHK({invalid_o, exc_vector_o}, {1'b1, `VEC_FLOAT_ERR})
        $display("range and load test done");
    endtask

    // reset for two cycles, then the scenarios
    initial begin
        clr;
        repeat (2) @(posedge mclk_i);
        #1 resetn_i = 1;
        t_access;
        t_env;
        t_arith;
        t_range;
        test_done;
    end
endmodule // fp_exception_and_op_rules_test
`default_nettype wire

// ==== operand_widen.v ====
// widens a memory operand to extended real and classifies it
`timescale 1ns/10ps
`default_nettype none
`include "fp_exc_consts.vh"

module operand_widen (
    // raw operand
    input  wire [79:0] raw_i,
    input  wire [1:0]  fmt_i,
    // widened operand and flags
    output reg  [79:0] ext_o,
    output reg         snan_o,
    output reg         denorm_o
);

    reg [63:0] man;
    reg [14:0] exp;
    reg        sgn;
    reg        is_den;
    reg        is_max;
    reg        frac_nz;
    reg [6:0]  lz;
    integer    i;

    // convert single or double; extended passes unchanged
    always @* begin
        man     = 64'h0;
        exp     = 15'h0;
        sgn     = 1'b0;
        is_den  = 1'b0;
        is_max  = 1'b0;
        frac_nz = 1'b0;
        lz      = 7'h0;
        snan_o  = 1'b0;
        denorm_o = 1'b0;
        ext_o   = raw_i;
        if (fmt_i == `FMT_SINGLE) begin
            sgn     = raw_i[31];
            frac_nz = |raw_i[22:0];
            is_den  = (raw_i[30:23] == 8'h00) && frac_nz;
            is_max  = &raw_i[30:23];
            man     = {(raw_i[30:23] != 8'h00), raw_i[22:0], 40'h0};
            exp     = {7'h0, raw_i[30:23]} - `EXP_SGL_BIAS + `EXP_BIAS;
        end else if (fmt_i == `FMT_DOUBLE) begin
            sgn     = raw_i[63];
            frac_nz = |raw_i[51:0];
            is_den  = (raw_i[62:52] == 11'h000) && frac_nz;
            is_max  = &raw_i[62:52];
            man     = {(raw_i[62:52] != 11'h000), raw_i[51:0], 11'h0};
            exp     = {4'h0, raw_i[62:52]} - `EXP_DBL_BIAS + `EXP_BIAS;
        end
        // leading zeros, used only for denormal sources
        for (i = 0; i < 64; i = i + 1) begin
            if (man[i]) begin
                lz = 7'd63 - i[6:0];
            end
        end
        if (fmt_i != `FMT_EXT) begin
            if (is_max) begin
                // snan is quieted here; the invalid flag carries the event
                snan_o = frac_nz && !man[62];
                ext_o  = {sgn, `EXP_MAX, man[63], man[62] | frac_nz, man[61:0]};
            end else if (is_den) begin
                // true normalisation, never an unnormal
                ext_o = {sgn, ((fmt_i == `FMT_SINGLE) ? `EXP_SGL_DEN : `EXP_DBL_DEN)
                        - {8'h0, lz}, man << lz};
                denorm_o = 1'b1;
            end else if (!man[63]) begin
                ext_o = {sgn, 79'h0};
            end else begin
                ext_o = {sgn, exp, man};
            end
        end
    end

endmodule // operand_widen
`default_nettype wire
